// [inc/dfr_defs.svh]
`ifndef DFR_DEFS_SVH
`define DFR_DEFS_SVH

// Register map of the host byte port
`define DFR_ADDR_WIN_FIRST 8'h00
`define DFR_ADDR_WIN_LAST  8'h31
`define DFR_ADDR_FLUSH     8'h32
`define DFR_ADDR_BYTES_LO  8'h38
`define DFR_ADDR_BYTES_HI  8'h39

// Flush register codes and reset value
`define DFR_FLUSH_NOP      8'h00
`define DFR_FLUSH_ALL      8'hff
`define DFR_FLUSH_RESET    8'h00

// Sensor identifiers above this value are wake-up variants
`define DFR_WAKE_ID_LIMIT  8'h20

// Buffer geometry: two buffers of equal depth share one memory
`define DFR_DEPTH          7'h40
`define DFR_PTR_W          6
`define DFR_TOTAL_BYTES    16'h0080
`define DFR_NSENS          4

// Latency timers count milliseconds
`define DFR_CLK_PERIOD_NS  10
`define DFR_MS_NS          1000000

`endif

// [inc/dfr_pkg.sv]
package dfr_pkg;

	typedef enum logic [1:0] {
		DFR_EV_SAMPLE      = 2'h0,
		DFR_EV_META_GLOBAL = 2'h1,
		DFR_EV_META_SENSOR = 2'h2,
		DFR_EV_TIMESTAMP   = 2'h3
	} dfr_kind_t;

	typedef struct packed {
		logic       valid;
		dfr_kind_t  kind;
		logic [7:0] sensor_id;
		logic [1:0] slot;
		logic [7:0] data;
	} dfr_event_t;

	typedef struct packed {
		logic [6:0] wm_wake;
		logic [6:0] wm_nonwake;
		logic       irq_dis_wake;
		logic       irq_dis_nonwake;
		logic       host_suspended;
		logic       update_count;
	} dfr_ctrl_t;

	typedef enum logic [1:0] {
		DFR_CLASS_CONT    = 2'h0,
		DFR_CLASS_CHANGE  = 2'h1,
		DFR_CLASS_ONESHOT = 2'h2
	} dfr_class_t;

	typedef struct packed {
		logic               present;
		logic [7:0]         sensor_type;
		logic [7:0]         driver_id;
		logic [7:0]         driver_version;
		logic signed [15:0] full_scale_value;
		logic signed [15:0] resolution;
		logic [7:0]         power;
		logic [15:0]        max_rate;
		logic [7:0]         min_rate;
		logic [7:0]         sample_size;
		dfr_class_t         sclass;
		logic [31:0]        period_min_us;
		logic [31:0]        period_max_us;
	} dfr_desc_t;

	typedef struct packed {
		logic [7:0]         sensor_type;
		logic [7:0]         driver_id;
		logic [7:0]         driver_version;
		logic signed [15:0] full_scale_value;
		logic signed [15:0] resolution;
		logic [7:0]         power;
		logic [15:0]        max_rate;
		logic [7:0]         min_rate;
		logic [15:0]        reserved_event_count;
		logic [15:0]        max_batch_event_count;
		logic signed [31:0] min_period_report;
		logic [31:0]        max_period_report;
	} dfr_info_t;

	typedef struct packed {
		logic       nack;
		logic       identity_fault;
		logic       transient;
		logic [2:0] power_mode;
	} dfr_health_t;

	typedef enum logic [1:0] {
		DFR_ST_IDLE = 2'b01,
		DFR_ST_XFER = 2'b10
	} dfr_state_t;

endpackage

// [rtl/dfr_event_mem.sv]
`timescale 1ns/10ps
`include "dfr_defs.svh"

// Shared event store: low half wake-up buffer, high half non-wake-up buffer
module dfr_event_mem (
	input  wire logic                  clock,
	input  wire logic                  wr_en,
	input  wire logic [`DFR_PTR_W:0]   wr_addr,
	input  wire logic [7:0]            wr_data,
	input  wire logic [`DFR_PTR_W:0]   rd_addr,
	output logic      [7:0]            rd_data
);

	logic [7:0] mem [0:(2**(`DFR_PTR_W+1))-1];

	// No reset on the array; read data always comes out of a flop
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule

// [rtl/dfr_readout.sv]
`timescale 1ns/10ps
`include "dfr_defs.svh"

module dfr_readout #(
	parameter int MS_CYCLES    = `DFR_MS_NS / `DFR_CLK_PERIOD_NS,
	parameter bit META_IRQ_EN  = 1'b1
) (
	input  wire logic                                 clock,
	input  wire logic                                 resetn,
	input  wire logic [7:0]                           reg_addr,
	input  wire logic                                 reg_rd,
	input  wire logic                                 reg_wr,
	input  wire logic [7:0]                           reg_wdata,
	output logic      [7:0]                           reg_rdata,
	input  wire dfr_pkg::dfr_event_t                  ev,
	output logic                                      ev_ready,
	input  wire dfr_pkg::dfr_ctrl_t                   ctrl,
	input  wire logic [`DFR_NSENS-1:0][15:0]          lat_ms,
	input  wire dfr_pkg::dfr_health_t [`DFR_NSENS-1:0] health,
	input  wire dfr_pkg::dfr_desc_t                   desc,
	output dfr_pkg::dfr_info_t                        info_q,
	output logic      [`DFR_NSENS-1:0][7:0]           status_q,
	output logic                                      host_irq,
	output logic      [5:0]                           irq_cause_q
);

	localparam int PW = `DFR_PTR_W;
	localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

	function automatic logic is_wake(input logic [7:0] id);
		return id > `DFR_WAKE_ID_LIMIT;
	endfunction

	// Static information with the derived fields filled in
	function automatic dfr_pkg::dfr_info_t build_info(input dfr_pkg::dfr_desc_t d);
		dfr_pkg::dfr_info_t r;
		r = '0;
		if (d.present) begin
			r.sensor_type      = d.sensor_type;
			r.driver_id        = d.driver_id;
			r.driver_version   = d.driver_version;
			r.full_scale_value = d.full_scale_value;
			r.resolution       = d.resolution;
			r.power            = d.power;
			r.max_rate         = d.max_rate;
			r.min_rate         = d.min_rate;
			r.reserved_event_count = 16'h0000;
			r.max_batch_event_count = (d.sample_size == 8'h00) ? 16'h0000 :
				`DFR_TOTAL_BYTES / {8'h00, d.sample_size};
			unique case (d.sclass)
				dfr_pkg::DFR_CLASS_CHANGE:  r.min_period_report = 32'sh00000000;
				dfr_pkg::DFR_CLASS_ONESHOT: r.min_period_report = -32'sh00000001;
				default:                    r.min_period_report = signed'(d.period_min_us);
			endcase
			r.max_period_report = d.period_max_us;
		end
		return r;
	endfunction

	// Buffer pointers and counts
	logic [PW-1:0] wh_q, wh_d, wt_q, wt_d, nh_q, nh_d, nt_q, nt_d;
	logic [PW:0]   wc_q, wc_d, nc_q, nc_d;
	logic          ts_pend_q, ts_pend_d;
	logic [7:0]    ts_byte_q, ts_byte_d;
	logic          push_w, push_n, drop_n, pop, pop_w, pop_n, take;
	logic          mem_we;
	logic [PW:0]   mem_wa, mem_ra;
	logic [7:0]    mem_wd, mem_rd;
	logic          wfull, nfull, n_block, is_sample, ev_wake;

	// Transfer control
	dfr_pkg::dfr_state_t st_q, st_d;
	logic [PW:0]   xw_q, xw_d, xn_q, xn_d;
	logic [15:0]   rem_q, rem_d;
	logic          irq_q, irq_d, susp_q, res_q, res_d;
	logic [5:0]    cause_d;
	logic [7:0]    flush_q, flush_d;
	logic          imm_w_q, imm_w_d, imm_n_q, imm_n_d, lat_w_q, lat_w_d, lat_n_q, lat_n_d;
	logic          start, sel_w, sel_n, wm_w, wm_n, imm_w, imm_n;

	// Latency timers and per-sensor flags
	logic [16:0]                    ms_q, ms_d;
	logic [`DFR_NSENS-1:0]          arm_q, arm_d, swake_q, swake_d, avail_q, avail_d, lost_q, lost_d;
	logic [`DFR_NSENS-1:0][15:0]    left_q, left_d;
	logic                           exp_w, exp_n, tick;

	// Register read path
	logic       win_q, win_d;
	logic [7:0] rdata_q, rdata_d, hi_q, hi_d;

	dfr_event_mem u_mem (
		.clock   (clock),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (mem_wd),
		.rd_addr (mem_ra),
		.rd_data (mem_rd)
	);

	// Window reads pop the head of the buffer being streamed
	assign pop    = reg_rd && (reg_addr <= `DFR_ADDR_WIN_LAST) && (st_q == dfr_pkg::DFR_ST_XFER)
		&& (rem_q != 16'h0000);
	assign pop_w  = pop && (xw_q != '0);
	assign pop_n  = pop && (xw_q == '0);
	assign mem_ra = (xw_q != '0) ? {1'b0, wh_q} : {1'b1, nh_q};

	// Routing into the buffers; a timestamp takes two write cycles
	always_comb begin
		is_sample = ev.kind == dfr_pkg::DFR_EV_SAMPLE;
		ev_wake   = is_sample && is_wake(ev.sensor_id);
		wfull     = (wc_q == `DFR_DEPTH) && !pop_w;
		nfull     = (nc_q == `DFR_DEPTH) && !pop_n;
		n_block   = nfull && !ctrl.host_suspended;
		if (ts_pend_q) begin
			ev_ready = 1'b0;
		end else if (ev.kind == dfr_pkg::DFR_EV_TIMESTAMP) begin
			ev_ready = !wfull && !n_block;
		end else begin
			ev_ready = ev_wake ? !wfull : !n_block;
		end
		take      = ev.valid && ev_ready;
		push_w    = 1'b0;
		push_n    = 1'b0;
		mem_wd    = ev.data;
		ts_pend_d = 1'b0;
		ts_byte_d = ts_byte_q;
		if (ts_pend_q) begin
			push_n = 1'b1;
			mem_wd = ts_byte_q;
		end else if (take) begin
			if (ev.kind == dfr_pkg::DFR_EV_TIMESTAMP) begin
				push_w    = 1'b1;
				ts_pend_d = 1'b1;
				ts_byte_d = ev.data;
			end else begin
				push_w = ev_wake;
				push_n = !ev_wake;
			end
		end
		drop_n = push_n && nfull;
		mem_we = push_w || push_n;
		mem_wa = push_w ? {1'b0, wt_q} : {1'b1, nt_q};
		wt_d   = wt_q + PW'(push_w);
		wh_d   = wh_q + PW'(pop_w);
		wc_d   = wc_q + (PW+1)'(push_w) - (PW+1)'(pop_w);
		nt_d   = nt_q + PW'(push_n);
		nh_d   = nh_q + PW'(pop_n || drop_n);
		nc_d   = nc_q + (PW+1)'(push_n && !drop_n) - (PW+1)'(pop_n);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wh_q      <= '0;
			wt_q      <= '0;
			wc_q      <= '0;
			nh_q      <= '0;
			nt_q      <= '0;
			nc_q      <= '0;
			ts_pend_q <= 1'b0;
			ts_byte_q <= 8'h00;
		end else begin
			wh_q      <= wh_d;
			wt_q      <= wt_d;
			wc_q      <= wc_d;
			nh_q      <= nh_d;
			nt_q      <= nt_d;
			nc_q      <= nc_d;
			ts_pend_q <= ts_pend_d;
			ts_byte_q <= ts_byte_d;
		end
	end

	// Pulses of immediate reporting from the accepted event
	assign imm_w = take && is_sample && ev_wake && (lat_ms[ev.slot] == 16'h0000);
	assign imm_n = take && ((is_sample && !ev_wake && (lat_ms[ev.slot] == 16'h0000))
		|| ((ev.kind == dfr_pkg::DFR_EV_META_GLOBAL) && META_IRQ_EN));
	assign wm_w  = (wc_q != '0) && (wc_q >= ctrl.wm_wake) && !ctrl.irq_dis_wake;
	assign wm_n  = (nc_q != '0) && (nc_q >= ctrl.wm_nonwake) && !ctrl.irq_dis_nonwake
		&& !ctrl.host_suspended;

	// Transfer sequencing: choose buffers, announce count, stream, acknowledge
	always_comb begin
		st_d    = st_q;
		xw_d    = xw_q;
		xn_d    = xn_q;
		rem_d   = rem_q;
		irq_d   = irq_q;
		cause_d = irq_cause_q;
		sel_w   = 1'b0;
		sel_n   = 1'b0;
		start   = 1'b0;
		res_d   = res_q || (susp_q && !ctrl.host_suspended);
		flush_d = flush_q;
		if (st_q == dfr_pkg::DFR_ST_IDLE) begin
			if (flush_q != `DFR_FLUSH_NOP) begin
				sel_w   = (flush_q == `DFR_FLUSH_ALL) || is_wake(flush_q);
				sel_n   = (flush_q == `DFR_FLUSH_ALL) || !is_wake(flush_q);
				start   = 1'b1;
				flush_d = `DFR_FLUSH_NOP;
			end else if (res_q || wm_w || wm_n || lat_w_q || imm_w_q
				|| (!ctrl.host_suspended && (lat_n_q || imm_n_q))) begin
				sel_w = 1'b1;
				sel_n = !ctrl.host_suspended || res_q;
				start = 1'b1;
			end
		end
		if (start) begin
			xw_d    = sel_w ? wc_q : '0;
			xn_d    = sel_n ? nc_q : '0;
			rem_d   = 16'({9'h000, xw_d} + {9'h000, xn_d});
			cause_d = {imm_n_q, lat_n_q, wm_n, imm_w_q, lat_w_q, wm_w};
			if (rem_d != 16'h0000) begin
				st_d  = dfr_pkg::DFR_ST_XFER;
				irq_d = 1'b1;
			end
			res_d = susp_q && !ctrl.host_suspended; // A resume in the start cycle is not lost
		end else if (pop) begin
			xw_d  = pop_w ? xw_q - 1'b1 : xw_q;
			xn_d  = pop_n ? xn_q - 1'b1 : xn_q;
			rem_d = rem_q - 16'h0001;
			if (rem_q == 16'h0001) begin
				st_d  = dfr_pkg::DFR_ST_IDLE;
				irq_d = 1'b0;
			end
		end else if (ctrl.update_count) begin
			xw_d  = wc_q;
			xn_d  = nc_q;
			rem_d = 16'({9'h000, wc_q} + {9'h000, nc_q});
			st_d  = (rem_d != 16'h0000) ? dfr_pkg::DFR_ST_XFER : dfr_pkg::DFR_ST_IDLE;
		end
		// New events win over the clear that a starting transfer applies
		imm_w_d = imm_w || (imm_w_q && !(start && sel_w));
		imm_n_d = imm_n || (imm_n_q && !(start && sel_n));
		lat_w_d = exp_w || (lat_w_q && !(start && sel_w));
		lat_n_d = exp_n || (lat_n_q && !(start && sel_n));
		if (reg_wr && (reg_addr == `DFR_ADDR_FLUSH)) begin
			flush_d = reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q        <= dfr_pkg::DFR_ST_IDLE;
			xw_q        <= '0;
			xn_q        <= '0;
			rem_q       <= 16'h0000;
			irq_q       <= 1'b0;
			irq_cause_q <= 6'h00;
			susp_q      <= 1'b0;
			res_q       <= 1'b0;
			flush_q     <= `DFR_FLUSH_RESET;
			imm_w_q     <= 1'b0;
			imm_n_q     <= 1'b0;
			lat_w_q     <= 1'b0;
			lat_n_q     <= 1'b0;
		end else begin
			st_q        <= st_d;
			xw_q        <= xw_d;
			xn_q        <= xn_d;
			rem_q       <= rem_d;
			irq_q       <= irq_d;
			irq_cause_q <= cause_d;
			susp_q      <= ctrl.host_suspended;
			res_q       <= res_d;
			flush_q     <= flush_d;
			imm_w_q     <= imm_w_d;
			imm_n_q     <= imm_n_d;
			lat_w_q     <= lat_w_d;
			lat_n_q     <= lat_n_d;
		end
	end

	assign host_irq = irq_q;

	// Per-sensor batching timers in milliseconds, plus data flags
	always_comb begin
		tick  = ms_q == MS_LAST;
		ms_d  = tick ? 17'h00000 : ms_q + 17'h00001;
		exp_w = 1'b0;
		exp_n = 1'b0;
		arm_d   = arm_q;
		left_d  = left_q;
		swake_d = swake_q;
		avail_d = avail_q;
		lost_d  = lost_q;
		for (int i = 0; i < `DFR_NSENS; i++) begin
			if (arm_q[i] && (left_q[i] == 16'h0000)) begin
				exp_w    = exp_w || swake_q[i];
				exp_n    = exp_n || !swake_q[i];
				arm_d[i] = 1'b0;
			end else if (arm_q[i] && tick) begin
				left_d[i] = left_q[i] - 16'h0001;
			end
			// Delivery of a buffer ends the batch of its sensors
			if (start && (swake_q[i] ? sel_w : sel_n)) begin
				arm_d[i]   = 1'b0;
				avail_d[i] = 1'b0;
				if (!swake_q[i]) begin
					lost_d[i] = 1'b0;
				end
			end
			if (drop_n && avail_q[i] && !swake_q[i]) begin
				lost_d[i] = 1'b1;
			end
			if (take && is_sample && (ev.slot == 2'(i))) begin
				swake_d[i] = ev_wake;
				avail_d[i] = 1'b1;
				if (!arm_q[i] && (lat_ms[i] != 16'h0000)) begin
					arm_d[i]  = 1'b1;
					left_d[i] = lat_ms[i];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ms_q    <= 17'h00000;
			arm_q   <= '0;
			left_q  <= '0;
			swake_q <= '0;
			avail_q <= '0;
			lost_q  <= '0;
		end else begin
			ms_q    <= ms_d;
			arm_q   <= arm_d;
			left_q  <= left_d;
			swake_q <= swake_d;
			avail_q <= avail_d;
			lost_q  <= lost_d;
		end
	end

	// Register reads; the high count byte is frozen when the low one is read
	always_comb begin
		win_d   = pop;
		rdata_d = 8'h00;
		hi_d    = hi_q;
		if (reg_rd) begin
			unique case (reg_addr)
				`DFR_ADDR_FLUSH: rdata_d = flush_q;
				`DFR_ADDR_BYTES_LO: begin
					rdata_d = rem_q[7:0];
					hi_d    = rem_q[15:8];
				end
				`DFR_ADDR_BYTES_HI: rdata_d = hi_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			win_q    <= 1'b0;
			rdata_q  <= 8'h00;
			hi_q     <= 8'h00;
			info_q   <= '0;
			status_q <= '0;
		end else begin
			win_q    <= win_d;
			rdata_q  <= rdata_d;
			hi_q     <= hi_d;
			info_q   <= build_info(desc);
			for (int i = 0; i < `DFR_NSENS; i++) begin
				// Power mode zero marks an absent sensor
				status_q[i] <= (health[i].power_mode == 3'h0) ? 8'h00 :
					{health[i].power_mode, lost_q[i], health[i].transient,
					health[i].identity_fault, health[i].nack, avail_q[i]};
			end
		end
	end

	assign reg_rdata = win_q ? mem_rd : rdata_q;

endmodule

// [sim/dfr_readout_monitor.sv]
`timescale 1ns/10ps
`include "dfr_defs.svh"

// Port-level checks on the readout block; it sees only the block's ports
module dfr_readout_monitor (
	input wire logic					clock,
	input wire logic					resetn,
	input wire logic [7:0]					reg_addr,
	input wire logic					reg_rd,
	input wire logic [7:0]					reg_rdata,
	input wire dfr_pkg::dfr_event_t				ev,
	input wire logic					ev_ready,
	input wire dfr_pkg::dfr_health_t [`DFR_NSENS-1:0]	health,
	input wire dfr_pkg::dfr_desc_t				desc,
	input wire dfr_pkg::dfr_info_t				info_q,
	input wire logic [`DFR_NSENS-1:0][7:0]			status_q,
	input wire logic					host_irq,
	input wire logic [5:0]					irq_cause_q
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// Reads above the map must not leak stale data
	property p_unmapped_zero;
		reg_rd && reg_addr > 8'h39 |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	// A timestamp is written twice, so the port is busy one more cycle
	property p_ts_block;
		ev.valid && ev_ready && ev.kind == dfr_pkg::DFR_EV_TIMESTAMP |=> !ev_ready;
	endproperty
	a_ts_block: assert property (p_ts_block) else $error("timestamp not blocking");

	// Cause bits are frozen for the whole transfer
	property p_cause_hold;
		host_irq && $past(host_irq) |-> $stable(irq_cause_q);
	endproperty
	a_cause_hold: assert property (p_cause_hold) else $error("cause moved in transfer");

	// Information fields follow the descriptor one cycle later
	property p_info_copy;
		desc.present && desc.sample_size != 8'h00 |=> info_q.sensor_type == $past(desc.sensor_type)
			&& info_q.power == $past(desc.power) && info_q.max_rate == $past(desc.max_rate)
			&& info_q.max_batch_event_count == `DFR_TOTAL_BYTES / $past(desc.sample_size);
	endproperty
	a_info_copy: assert property (p_info_copy) else $error("info fields wrong");

	property p_info_absent;
		!desc.present |=> info_q == '0;
	endproperty
	a_info_absent: assert property (p_info_absent) else $error("absent info not zero");

	property p_reserved_zero;
		info_q.reserved_event_count == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved count not zero");

	// Class decides the minimum period encoding
	property p_min_period;
		desc.present |=> info_q.min_period_report == ($past(desc.sclass) == dfr_pkg::DFR_CLASS_ONESHOT ? 32'hffffffff
			: $past(desc.sclass) == dfr_pkg::DFR_CLASS_CHANGE ? 32'h00000000 : $past(desc.period_min_us));
	endproperty
	a_min_period: assert property (p_min_period) else $error("min period wrong");

	// Slot zero status byte tracks its health inputs
	property p_status_flags;
		health[0].power_mode != 3'h0 |=> status_q[0][7:5] == $past(health[0].power_mode)
			&& status_q[0][1] == $past(health[0].nack) && status_q[0][3] == $past(health[0].transient);
	endproperty
	a_status_flags: assert property (p_status_flags) else $error("status byte wrong");
endmodule

// [sim/dfr_host_model.sv]
`timescale 1ns/10ps

// Host processor on the byte port; gap slows it down between reads
module dfr_host_model (
	input  wire logic	clock,
	input  wire logic [7:0]	reg_rdata,
	output logic [7:0]	reg_addr,
	output logic		reg_rd,
	output logic		reg_wr,
	output logic [7:0]	reg_wdata
);
	int gap = 0;

	// Idle bus at time zero
	initial begin
		reg_addr = 8'hff;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end

	// One write strobe, then the bus is released with changed values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock);
		#1 reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// Reads n bytes; the strobe stays up between reads when gap is zero
	task automatic rd_seq(input logic [7:0] a0, input int n, output logic [7:0] q[$]);
		q = {};
		@(posedge clock);
		#1;
		for (int i = 0; i < n; i++) begin
			reg_addr = a0 + 8'(i % 50);
			reg_rd = 1'b1;
			@(posedge clock);
			#1 q.push_back(reg_rdata);
			if (gap != 0 || i == n - 1) begin
				reg_rd = 1'b0;
				reg_addr = ~reg_addr;
				repeat (gap) @(posedge clock);
				if (gap != 0) #1;
			end
		end
	endtask

	// Count first, then exactly that many window bytes
	task automatic drain(output logic [7:0] q[$]);
		logic [7:0] c[$];
		rd_seq(8'h38, 2, c);
		rd_seq(8'h00, int'({c[1], c[0]}), q);
	endtask
endmodule

// [sim/test_dual_event_fifo_readout.sv]
`timescale 1ns/10ps
`include "dfr_defs.svh"

// Self-checking bench: host model on the byte port, bench feeds events
module test_dual_event_fifo_readout;
	logic					clock = 1'b0;
	logic					resetn = 1'b0;
	logic [7:0]				reg_addr, reg_wdata, reg_rdata;
	logic					reg_rd, reg_wr, ev_ready, host_irq;
	dfr_pkg::dfr_event_t			ev;
	dfr_pkg::dfr_ctrl_t			ctrl;
	logic [`DFR_NSENS-1:0][15:0]		lat_ms;
	dfr_pkg::dfr_health_t [`DFR_NSENS-1:0]	health;
	dfr_pkg::dfr_desc_t			desc;
	dfr_pkg::dfr_info_t			info_q;
	logic [`DFR_NSENS-1:0][7:0]		status_q;
	logic [5:0]				irq_cause_q;
	int					n_mismatch = 0;
	int					n_tests = 0;
	localparam dfr_pkg::dfr_kind_t k_smp = dfr_pkg::DFR_EV_SAMPLE;
	localparam dfr_pkg::dfr_kind_t k_ts = dfr_pkg::DFR_EV_TIMESTAMP;

	// 100 MHz
	always #5 clock = ~clock;

	// Short millisecond tick keeps latency scenarios brief
	dfr_readout #(.MS_CYCLES(10)) dut (.clock, .resetn, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
		.ev, .ev_ready, .ctrl, .lat_ms, .health, .desc, .info_q, .status_q, .host_irq, .irq_cause_q);
	dfr_host_model host (.clock, .reg_rdata, .reg_addr, .reg_rd, .reg_wr, .reg_wdata);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Offer one event byte; ready is judged at the falling edge to stay clear of the flops
	task automatic put(input dfr_pkg::dfr_kind_t k, input logic [7:0] id, input logic [1:0] s, input logic [7:0] d);
		int w;
		@(posedge clock);
		#1 ev = '{1'b1, k, id, s, d};
		@(negedge clock);
		for (w = 0; w < 200 && !ev_ready; w++) @(negedge clock);
		if (!ev_ready) check("ev_ready", ev_ready, 1'b1);
		@(posedge clock);
		#1 ev.valid = 1'b0;
		ev.data = ~d;
	endtask

	task automatic fl(input logic [7:0] code);
		host.wr(`DFR_ADDR_FLUSH, code);
	endtask

	// Wait for the request, drain it and compare every byte
	task automatic xfer(input logic [7:0] e[$]);
		logic [7:0] q[$];
		int w;
		for (w = 0; w < 300 && host_irq !== 1'b1; w++) @(negedge clock);
		check("host_irq", host_irq, 1'b1);
		host.drain(q);
		check("count", q.size(), e.size());
		foreach (e[i]) check("byte", q[i], e[i]);
		check("irq drop", host_irq, 1'b0);
	endtask

	task automatic t_regs;
		logic [7:0] q[$];
		host.rd_seq(8'h50, 1, q);
		check("unmapped", q[0], 8'h00);
		host.rd_seq(8'h00, 1, q);
		check("idle window", q[0], 8'h00);
		host.rd_seq(`DFR_ADDR_FLUSH, 1, q);
		check("flush reset", q[0], `DFR_FLUSH_RESET);
		check("absent status", status_q[3], 8'h00);
	endtask

	// Id 33 is wake-up, id 32 is not; a full flush sends wake bytes first
	task automatic t_order;
		logic [7:0] q[$];
		put(k_smp, 8'h05, 2'h0, 8'ha1);
		put(k_smp, 8'h21, 2'h1, 8'hb1);
		put(k_smp, 8'h05, 2'h0, 8'ha2);
		put(k_smp, 8'h20, 2'h1, 8'hc1);
		check("no early irq", host_irq, 1'b0);
		fl(`DFR_FLUSH_ALL);
		xfer({8'hb1, 8'ha1, 8'ha2, 8'hc1});
		host.rd_seq(`DFR_ADDR_FLUSH, 1, q);
		check("flush cleared", q[0], `DFR_FLUSH_NOP);
	endtask

	// Per-id flush picks one buffer; sensor meta of a wake id sits in non-wake
	task automatic t_flush_id;
		put(k_smp, 8'h21, 2'h1, 8'hd1);
		put(dfr_pkg::DFR_EV_META_SENSOR, 8'h21, 2'h1, 8'he1);
		fl(`DFR_FLUSH_NOP);
		#50 check("nop flush", host_irq, 1'b0);
		fl(8'h21);
		xfer({8'hd1});
		fl(8'h05);
		xfer({8'he1});
	endtask

	// Zero latency and global meta raise the request; a count update announces without one
	task automatic t_immediate;
		logic [7:0] q[$];
		lat_ms[2] = 16'h0000;
		put(k_smp, 8'h07, 2'h2, 8'h71);
		xfer({8'h71});
		check("cause imm", irq_cause_q, 6'h20);
		lat_ms[2] = 16'hffff;
		put(dfr_pkg::DFR_EV_META_GLOBAL, 8'h00, 2'h0, 8'h4e);
		xfer({8'h4e});
		check("cause meta", irq_cause_q, 6'h20);
		put(k_smp, 8'h21, 2'h1, 8'h5a);
		@(posedge clock);
		#1 ctrl.update_count = 1'b1;
		@(posedge clock);
		#1 ctrl.update_count = 1'b0;
		check("no irq on update", host_irq, 1'b0);
		host.drain(q);
		check("update count", q.size(), 1);
		check("update byte", q[0], 8'h5a);
	endtask

	task automatic t_stamp;
		put(k_smp, 8'h21, 2'h1, 8'h91);
		put(k_ts, 8'h00, 2'h0, 8'h33);
		fl(`DFR_FLUSH_ALL);
		xfer({8'h91, 8'h33, 8'h33});
	endtask

	// Watermarks of three (non-wake) and one (wake), first held off by both disable bits
	task automatic t_watermark;
		ctrl.wm_nonwake = 7'h03;
		ctrl.wm_wake = 7'h01;
		ctrl.irq_dis_nonwake = 1'b1;
		ctrl.irq_dis_wake = 1'b1;
		put(k_smp, 8'h21, 2'h1, 8'h61);
		for (int i = 1; i < 4; i++) put(k_smp, 8'h05, 2'h0, 8'(i));
		#50 check("disabled", host_irq, 1'b0);
		ctrl.irq_dis_nonwake = 1'b0;
		ctrl.irq_dis_wake = 1'b0;
		xfer({8'h61, 8'h01, 8'h02, 8'h03});
		check("cause wm", irq_cause_q, 6'h09);
		ctrl.wm_nonwake = 7'h7f;
		ctrl.wm_wake = 7'h7f;
	endtask

	// Two millisecond timeout on slot 3 drains both buffers; slow host
	task automatic t_latency;
		host.gap = 2;
		lat_ms[3] = 16'h0002;
		put(k_smp, 8'h21, 2'h1, 8'h81);
		put(k_smp, 8'h08, 2'h3, 8'h82);
		check("before timeout", host_irq, 1'b0);
		xfer({8'h81, 8'h82});
		check("cause lat", irq_cause_q, 6'h10);
		lat_ms[3] = 16'hffff;
		host.gap = 0;
	endtask

	// Suspended host: 66 bytes into a 64 byte buffer lose the two oldest
	task automatic t_suspend;
		logic [7:0] e[$];
		ctrl.host_suspended = 1'b1;
		for (int i = 0; i < 66; i++) put(k_smp, 8'h05, 2'h0, 8'(i));
		for (int i = 2; i < 66; i++) e.push_back(8'(i));
		#20 check("no irq asleep", host_irq, 1'b0);
		check("data lost", status_q[0][4], 1'b1);
		ctrl.host_suspended = 1'b0;
		xfer(e);
	endtask

	task automatic t_info;
		#20 check("max count", info_q.max_batch_event_count, 16'h0015);
		check("power", info_q.power, 8'h05);
		check("period cont", info_q.min_period_report, 32'h00001388);
		desc.sclass = dfr_pkg::DFR_CLASS_CHANGE;
		#20 check("period change", info_q.min_period_report, 32'h00000000);
		desc.sclass = dfr_pkg::DFR_CLASS_ONESHOT;
		#20 check("period oneshot", info_q.min_period_report, 32'hffffffff);
		desc.present = 1'b0;
		#20 check("absent info", info_q === '0, 1'b1);
	endtask

	// Main sequence
	initial begin
		ev = '0;
		ctrl = '{7'h7f, 7'h7f, 1'b0, 1'b0, 1'b0, 1'b0};
		lat_ms = {4{16'hffff}};
		health = '0;
		health[0] = '{1'b1, 1'b0, 1'b1, 3'h4};
		health[1].power_mode = 3'h2;
		health[2].power_mode = 3'h3;
		desc = '{1'b1, 8'h11, 8'h22, 8'h03, 16'sh0400, 16'sh000c, 8'h05, 16'h00c8, 8'h01, 8'h06,
			dfr_pkg::DFR_CLASS_CONT, 32'h00001388, 32'h000f4240};
		repeat (12) @(posedge clock);
		#1 resetn = 1'b1;
		t_regs();
		t_order();
		t_flush_id();
		t_immediate();
		t_stamp();
		t_watermark();
		t_latency();
		t_suspend();
		t_info();
		results();
	end

	// The run needs about 400 cycles; 10000 means a hang
	initial begin
		#100000;
		n_mismatch++;
		results();
	end
endmodule

bind dfr_readout dfr_readout_monitor u_mon (.clock, .resetn, .reg_addr, .reg_rd, .reg_rdata, .ev, .ev_ready,
	.health, .desc, .info_q, .status_q, .host_irq, .irq_cause_q);
